// ### bench/pmicrb_host_model.sv
`timescale 1ns/1ps
module pmicrb_host_model (
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    // Released lines show the inverse, never a stale value
    addr <= ~a;
    wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    addr <= ~a;
    // Unknown unless an answer arrives in time
    d = 8'hxx;
    for (n = 0; n < 4; n++) begin
      @(posedge clk_sys);
      if (rvalid === 1'b1) begin
        d = rdata;
        break;
      end
    end
  endtask
endmodule // pmicrb_host_model

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic wr_en, rd_en, rvalid, enable_pin, soft_reset_pulse, load_select;
  logic [7:0] addr, wdata, rdata, rv;
  logic [3:0] power_good_fault_flags_in = 4'h0;
  logic [7:0] global_stat_in = 8'h00;
  logic [7:0] conv_stat_in = 8'h00;
  logic [7:0] lreg_stat_in = 8'h00;
  logic [8:0] load_current_in = 9'h1a5;
  pmicrb_pkg::pmicrb_events_t events = '0;
  pmicrb_pkg::pmicrb_conv0_drive_t conv0_drive;
  int failures = 0;
  int total_checks = 0;

  always #5 clk_sys = ~clk_sys;
  initial enable_pin = 1'b0;

  pmicrb_host_model host (.clk_sys(clk_sys), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata(rdata), .rvalid(rvalid));
  pmicrb_regbank DUT (.clk_sys(clk_sys), .rstn(rstn), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid), .enable_pin(enable_pin),
    .events(events), .power_good_fault_flags_in(power_good_fault_flags_in), .global_stat_in(global_stat_in),
    .conv_stat_in(conv_stat_in), .lreg_stat_in(lreg_stat_in),
    .load_current_in(load_current_in), .conv0_drive(conv0_drive),
    .soft_reset_pulse(soft_reset_pulse), .load_select(load_select));

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chk_drive(input logic [3:0] exp);
    total_checks++;
    if (conv0_drive !== exp) begin
      failures++;
      $display("unexpected conv0_drive: expected %b, seen %b", exp, conv0_drive);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic test_ids;
    host.rd(pmicrb_pkg::OFS_DEV_REVISION, rv);
    chk8("device_revision", {2'h1, 6'h02}, rv);
    host.rd(pmicrb_pkg::OFS_MEM_VERSION, rv);
    chk8("memory_version_id", 8'h5a, rv);
    host.wr(pmicrb_pkg::OFS_DEV_REVISION, 8'h3d);
    host.wr(pmicrb_pkg::OFS_MEM_VERSION, 8'ha5);
    host.rd(pmicrb_pkg::OFS_DEV_REVISION, rv);
    chk8("device_revision after write", {2'h1, 6'h02}, rv);
    host.rd(pmicrb_pkg::OFS_MEM_VERSION, rv);
    chk8("memory_version_id after write", 8'h5a, rv);
    host.rd(8'h30, rv);
    chk8("unmapped", 8'h00, rv);
    host.rd(pmicrb_pkg::OFS_LOAD_LOW, rv);
    chk8("load_current_low", 8'ha5, rv);
    host.rd(pmicrb_pkg::OFS_LOAD_HIGH, rv);
    chk8("load_current_high", 8'h01, rv);
    $display("test_ids done");
  endtask

  task automatic test_fields;
    host.rd(pmicrb_pkg::OFS_CONV0_CTRL_A, rv);
    chk8("converter0_control_a reset", 8'h04, rv);
    chk_drive(4'b0001);
    host.wr(pmicrb_pkg::OFS_CONV0_CTRL_A, 8'h10);
    settle(2);
    chk_drive(4'b0100);
    host.wr(pmicrb_pkg::OFS_CONV0_CTRL_A, 8'h08);
    settle(2);
    chk_drive(4'b0010);
    host.wr(pmicrb_pkg::OFS_CONV0_CTRL_A, 8'h05);
    settle(2);
    chk_drive(4'b1000);
    host.wr(pmicrb_pkg::OFS_CONV0_CTRL_A, 8'hff);
    host.rd(pmicrb_pkg::OFS_CONV0_CTRL_A, rv);
    chk8("converter0_control_a readback", 8'h1f, rv);
    $display("test_fields done");
  endtask

  task automatic test_pin;
    host.wr(pmicrb_pkg::OFS_CONV0_CTRL_A, 8'h07);
    settle(8);
    chk_drive(4'b0001);
    @(posedge clk_sys);
    enable_pin <= 1'b1;
    settle(8);
    chk_drive(4'b1000);
    host.wr(pmicrb_pkg::OFS_CONV0_CTRL_A, 8'h06);
    settle(2);
    chk_drive(4'b0001);
    host.wr(pmicrb_pkg::OFS_CONV0_CTRL_A, 8'h05);
    enable_pin <= 1'b0;
    settle(8);
    chk_drive(4'b1000);
    $display("test_pin done");
  endtask

  task automatic test_flags;
    @(posedge clk_sys);
    events.conv <= 8'hff;
    @(posedge clk_sys);
    events.conv <= 8'h00;
    host.rd(pmicrb_pkg::OFS_CONV_INT, rv);
    chk8("converter_interrupt_flags set", pmicrb_pkg::WM_SUB_INT, rv);
    host.wr(pmicrb_pkg::OFS_CONV_INT, 8'h05);
    host.rd(pmicrb_pkg::OFS_CONV_INT, rv);
    chk8("converter_interrupt_flags clear", 8'h72, rv);
    @(posedge clk_sys);
    events.conv <= 8'h02;
    host.wr(pmicrb_pkg::OFS_CONV_INT, 8'h02);
    events.conv <= 8'h00;
    host.rd(pmicrb_pkg::OFS_CONV_INT, rv);
    chk8("converter_interrupt_flags set wins", 8'h72, rv);
    host.wr(pmicrb_pkg::OFS_CONV_INT, 8'h02);
    host.rd(pmicrb_pkg::OFS_CONV_INT, rv);
    chk8("converter_interrupt_flags second clear", 8'h70, rv);
    $display("test_flags done");
  endtask

  task automatic test_misc;
    host.rd(pmicrb_pkg::OFS_PG_CFG_A, rv);
    chk8("power_good_config_a reset", pmicrb_pkg::RST_PG_CFG_A, rv);
    host.wr(pmicrb_pkg::OFS_PG_CFG_B, 8'hff);
    host.rd(pmicrb_pkg::OFS_PG_CFG_B, rv);
    chk8("power_good_config_b", pmicrb_pkg::WM_PG_CFG_B, rv);
    host.wr(pmicrb_pkg::OFS_MASK_A, 8'hff);
    host.rd(pmicrb_pkg::OFS_MASK_A, rv);
    chk8("global_irq_mask_a", pmicrb_pkg::WM_MASK_A, rv);
    host.wr(pmicrb_pkg::OFS_LOAD_SEL, 8'h01);
    settle(0);
    chk8("load_select", 8'h01, {7'h00, load_select});
    host.wr(pmicrb_pkg::OFS_SOFT_RESET, 8'h01);
    settle(0);
    chk8("soft_reset_pulse high", 8'h01, {7'h00, soft_reset_pulse});
    settle(1);
    chk8("soft_reset_pulse low", 8'h00, {7'h00, soft_reset_pulse});
    host.rd(pmicrb_pkg::OFS_SOFT_RESET, rv);
    chk8("soft_reset_control", 8'h00, rv);
    @(posedge clk_sys);
    global_stat_in <= 8'hff;
    host.rd(pmicrb_pkg::OFS_GLOBAL_STAT, rv);
    chk8("global_status", 8'h9e, rv);
    $display("test_misc done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    settle(1);
    test_ids();
    test_fields();
    test_pin();
    test_flags();
    test_misc();
    report_and_stop();
  end

  // Tests need well under a thousand cycles
  initial begin
    #100000;
    failures++;
    report_and_stop();
  end
endmodule // tb_top

// ### hw/pmicrb_pkg.sv
package pmicrb_pkg;
  // Register offsets
  localparam logic [7:0] OFS_DEV_REVISION = 8'h00;
  localparam logic [7:0] OFS_MEM_VERSION = 8'h01;
  localparam logic [7:0] OFS_CONV0_CTRL_A = 8'h02;
  localparam logic [7:0] OFS_PG_CFG_A = 8'h15;
  localparam logic [7:0] OFS_PG_CFG_B = 8'h16;
  localparam logic [7:0] OFS_POWER_GOOD_FAULT_FLAGS = 8'h17;
  localparam logic [7:0] OFS_SOFT_RESET = 8'h18;
  localparam logic [7:0] OFS_TOP_INT_A = 8'h19;
  localparam logic [7:0] OFS_TOP_INT_B = 8'h1a;
  localparam logic [7:0] OFS_CONV_INT = 8'h1b;
  localparam logic [7:0] OFS_LREG_INT = 8'h1c;
  localparam logic [7:0] OFS_GLOBAL_STAT = 8'h1d;
  localparam logic [7:0] OFS_CONV_STAT = 8'h1e;
  localparam logic [7:0] OFS_LREG_STAT = 8'h1f;
  localparam logic [7:0] OFS_MASK_A = 8'h20;
  localparam logic [7:0] OFS_MASK_B = 8'h21;
  localparam logic [7:0] OFS_CONV_MASK = 8'h22;
  localparam logic [7:0] OFS_LREG_MASK = 8'h23;
  localparam logic [7:0] OFS_LOAD_SEL = 8'h24;
  localparam logic [7:0] OFS_LOAD_HIGH = 8'h25;
  localparam logic [7:0] OFS_LOAD_LOW = 8'h26;
  // Converter 0 control field positions, and the part code position at offset zero
  localparam int BIT_MULTIPHASE = 4;
  localparam int BIT_FORCE_PWM = 3;
  localparam int BIT_DISCHARGE = 2;
  localparam int BIT_PIN_GATING = 1;
  localparam int BIT_SW_ENABLE = 0;
  localparam int PART_CODE_LSB = 6;
  // Reset values
  localparam logic [4:0] RST_CONV0_CTRL = 5'h04;
  localparam logic [5:0] RST_REV_LOW = 6'h02;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PG_CFG_A = 8'h0f;
  // Writable bit masks
  localparam logic [7:0] WM_PG_CFG_B = 8'h07;
  localparam logic [7:0] WM_TOP_INT_A = 8'hff;
  localparam logic [7:0] WM_TOP_INT_B = 8'h01;
  localparam logic [7:0] WM_SUB_INT = 8'h77;
  localparam logic [7:0] WM_MASK_A = 8'h95;
  localparam logic [7:0] WM_SUB_MASK = 8'hdd;

  typedef struct packed {
    logic force_multiphase;
    logic force_pwm;
    logic discharge_enable;
    logic pin_gating;
    logic software_enable;
  } pmicrb_conv0_ctrl_t;

  typedef struct packed {
    logic run;
    logic multiphase;
    logic force_pwm;
    logic discharge;
  } pmicrb_conv0_drive_t;

  typedef struct packed {
    logic [7:0] top_a;
    logic [7:0] top_b;
    logic [7:0] conv;
    logic [7:0] lreg;
  } pmicrb_events_t;
endpackage

// ### hw/pmicrb_regbank.sv
`timescale 1ns/1ps
// Summary of operation
// - Control bit 4 forces multiphase only, forced PWM follows bit 3; clear allows automatic phase shedding.
// - Control bit 3 forces PWM; clear allows automatic pulse skipping transitions.
// - Control bit 2, reset one, connects discharge resistor while converter disabled.
// - Control bit 1 selects enable source: software bit only, or bit and pin.
// - Control bit 0 is the software enable for converter 0.
// - Offset zero returns a read-only part code in bits 7 to 6.
// - Offset one returns a read-only eight-bit memory image code.
module pmicrb_regbank #(
  // Arbitrary neutral identification values
  parameter logic [1:0] PART_CODE = 2'h1,
  parameter logic [7:0] MEMORY_IMAGE_CODE = 8'h5a
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register port from the serial engine
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic rvalid,
  // Enable pin, asynchronous
  input wire logic enable_pin,
  // Analog side
  input wire pmicrb_pkg::pmicrb_events_t events,
  input wire logic [3:0] power_good_fault_flags_in,
  input wire logic [7:0] global_stat_in,
  input wire logic [7:0] conv_stat_in,
  input wire logic [7:0] lreg_stat_in,
  input wire logic [8:0] load_current_in,
  output pmicrb_pkg::pmicrb_conv0_drive_t conv0_drive,
  output logic soft_reset_pulse,
  output logic load_select
);
  pmicrb_pkg::pmicrb_conv0_ctrl_t ctrl_q;
  logic [7:0] pg_a_q, pg_b_q, int_a_q, int_b_q, int_c_q, int_l_q;
  logic [7:0] mask_a_q, mask_b_q, mask_c_q, mask_l_q;
  logic sel_q, srst_q, rvalid_q;
  logic [7:0] rdata_q;
  logic [2:0] pin_sync_q;
  logic pin_level_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // Sticky flags: hardware set beats write-one-to-clear
  function automatic logic [7:0] sticky(input logic [7:0] cur, input logic [7:0] set,
                                        input logic clr, input logic [7:0] wd,
                                        input logic [7:0] wm);
    return ((cur & ~(clr ? wd : 8'h00)) | set) & wm;
  endfunction

  wire logic wr_ctrl = wr_en && hit(addr, pmicrb_pkg::OFS_CONV0_CTRL_A);
  wire logic wr_pga = wr_en && hit(addr, pmicrb_pkg::OFS_PG_CFG_A);
  wire logic wr_pgb = wr_en && hit(addr, pmicrb_pkg::OFS_PG_CFG_B);
  wire logic wr_rst = wr_en && hit(addr, pmicrb_pkg::OFS_SOFT_RESET);
  wire logic wr_ia = wr_en && hit(addr, pmicrb_pkg::OFS_TOP_INT_A);
  wire logic wr_ib = wr_en && hit(addr, pmicrb_pkg::OFS_TOP_INT_B);
  wire logic wr_ic = wr_en && hit(addr, pmicrb_pkg::OFS_CONV_INT);
  wire logic wr_il = wr_en && hit(addr, pmicrb_pkg::OFS_LREG_INT);
  wire logic wr_ma = wr_en && hit(addr, pmicrb_pkg::OFS_MASK_A);
  wire logic wr_mb = wr_en && hit(addr, pmicrb_pkg::OFS_MASK_B);
  wire logic wr_mc = wr_en && hit(addr, pmicrb_pkg::OFS_CONV_MASK);
  wire logic wr_ml = wr_en && hit(addr, pmicrb_pkg::OFS_LREG_MASK);
  wire logic wr_sel = wr_en && hit(addr, pmicrb_pkg::OFS_LOAD_SEL);

  // Pin filter: change taken once second and third stages agree
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_sync_q <= 3'h0;
      pin_level_q <= 1'b0;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], enable_pin};
      if (pin_sync_q[1] == pin_sync_q[2]) begin
        pin_level_q <= pin_sync_q[2];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= pmicrb_pkg::RST_CONV0_CTRL;
    end else if (wr_ctrl) begin
      ctrl_q <= wdata[4:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pg_a_q <= pmicrb_pkg::RST_PG_CFG_A;
      pg_b_q <= pmicrb_pkg::RST_ZERO;
      mask_a_q <= pmicrb_pkg::RST_ZERO;
      mask_b_q <= pmicrb_pkg::RST_ZERO;
      mask_c_q <= pmicrb_pkg::RST_ZERO;
      mask_l_q <= pmicrb_pkg::RST_ZERO;
      sel_q <= 1'b0;
      srst_q <= 1'b0;
    end else begin
      if (wr_pga) pg_a_q <= wdata;
      if (wr_pgb) pg_b_q <= wdata & pmicrb_pkg::WM_PG_CFG_B;
      if (wr_ma) mask_a_q <= wdata & pmicrb_pkg::WM_MASK_A;
      if (wr_mb) mask_b_q <= wdata & pmicrb_pkg::WM_TOP_INT_B;
      if (wr_mc) mask_c_q <= wdata & pmicrb_pkg::WM_SUB_MASK;
      if (wr_ml) mask_l_q <= wdata & pmicrb_pkg::WM_SUB_MASK;
      if (wr_sel) sel_q <= wdata[0];
      // Self-clearing, so the bit never reads back as one
      srst_q <= wr_rst && wdata[0];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      int_a_q <= pmicrb_pkg::RST_ZERO;
      int_b_q <= pmicrb_pkg::RST_ZERO;
      int_c_q <= pmicrb_pkg::RST_ZERO;
      int_l_q <= pmicrb_pkg::RST_ZERO;
    end else begin
      int_a_q <= sticky(int_a_q, events.top_a, wr_ia, wdata, pmicrb_pkg::WM_TOP_INT_A);
      int_b_q <= sticky(int_b_q, events.top_b, wr_ib, wdata, pmicrb_pkg::WM_TOP_INT_B);
      int_c_q <= sticky(int_c_q, events.conv, wr_ic, wdata, pmicrb_pkg::WM_SUB_INT);
      int_l_q <= sticky(int_l_q, events.lreg, wr_il, wdata, pmicrb_pkg::WM_SUB_INT);
    end
  end

  wire logic pin_term = ctrl_q.pin_gating ? pin_level_q : 1'b1;
  wire logic run_w = ctrl_q.software_enable && pin_term;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      conv0_drive <= '0;
    end else begin
      conv0_drive.run <= run_w;
      conv0_drive.multiphase <= ctrl_q.force_multiphase;
      conv0_drive.force_pwm <= ctrl_q.force_pwm;
      conv0_drive.discharge <= ctrl_q.discharge_enable && !run_w;
    end
  end

  // Read mux
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (addr)
      pmicrb_pkg::OFS_DEV_REVISION: rd_mux = {PART_CODE, pmicrb_pkg::RST_REV_LOW};
      pmicrb_pkg::OFS_MEM_VERSION: rd_mux = MEMORY_IMAGE_CODE;
      pmicrb_pkg::OFS_CONV0_CTRL_A: rd_mux = {3'h0, ctrl_q};
      pmicrb_pkg::OFS_PG_CFG_A: rd_mux = pg_a_q;
      pmicrb_pkg::OFS_PG_CFG_B: rd_mux = pg_b_q;
      pmicrb_pkg::OFS_POWER_GOOD_FAULT_FLAGS: rd_mux = {4'h0, power_good_fault_flags_in};
      pmicrb_pkg::OFS_TOP_INT_A: rd_mux = int_a_q;
      pmicrb_pkg::OFS_TOP_INT_B: rd_mux = int_b_q;
      pmicrb_pkg::OFS_CONV_INT: rd_mux = int_c_q;
      pmicrb_pkg::OFS_LREG_INT: rd_mux = int_l_q;
      pmicrb_pkg::OFS_GLOBAL_STAT: rd_mux = global_stat_in & 8'h9e;
      pmicrb_pkg::OFS_CONV_STAT: rd_mux = conv_stat_in & 8'hdd;
      pmicrb_pkg::OFS_LREG_STAT: rd_mux = lreg_stat_in & 8'hdd;
      pmicrb_pkg::OFS_MASK_A: rd_mux = mask_a_q;
      pmicrb_pkg::OFS_MASK_B: rd_mux = mask_b_q;
      pmicrb_pkg::OFS_CONV_MASK: rd_mux = mask_c_q;
      pmicrb_pkg::OFS_LREG_MASK: rd_mux = mask_l_q;
      pmicrb_pkg::OFS_LOAD_SEL: rd_mux = {7'h00, sel_q};
      pmicrb_pkg::OFS_LOAD_HIGH: rd_mux = {7'h00, load_current_in[8]};
      pmicrb_pkg::OFS_LOAD_LOW: rd_mux = load_current_in[7:0];
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rd_en;
      if (rd_en) rdata_q <= rd_mux;
    end
  end

  assign rdata = rdata_q;
  assign rvalid = rvalid_q;
  assign soft_reset_pulse = srst_q;
  assign load_select = sel_q;

  // Assertions
  // gated run blocked
  a_run_gated: assert property (@(posedge clk_sys) disable iff (!rstn)
    ctrl_q.pin_gating && !pin_level_q |=> !conv0_drive.run)
    else $error("converter ran with pin low while gated");

  a_run_sw_only: assert property (@(posedge clk_sys) disable iff (!rstn)
    !ctrl_q.pin_gating |=> conv0_drive.run == $past(ctrl_q.software_enable))
    else $error("software-only enable mismatch");

  a_sw_off: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_ctrl && !wdata[0] |=> ##1 !conv0_drive.run)
    else $error("converter still running after disable");

  a_discharge_off: assert property (@(posedge clk_sys) disable iff (!rstn)
    conv0_drive.discharge |-> !conv0_drive.run)
    else $error("discharge while running");

  a_discharge_reset: assert property (@(posedge clk_sys)
    $rose(rstn) |-> ctrl_q.discharge_enable)
    else $error("discharge default not one");

  a_multiphase_follow: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_ctrl |=> ##1 conv0_drive.multiphase == $past(wdata[4], 2))
    else $error("multiphase not following write");

  a_pwm_follow: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_ctrl |=> ##1 conv0_drive.force_pwm == $past(wdata[3], 2))
    else $error("forced pwm not following write");

  a_part_code: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_en && addr == pmicrb_pkg::OFS_DEV_REVISION |=> rdata[7:6] == PART_CODE)
    else $error("part code wrong");

  a_image_code: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_en && addr == pmicrb_pkg::OFS_MEM_VERSION |=> rdata == MEMORY_IMAGE_CODE)
    else $error("image code wrong");

  a_ctrl_reserved: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_en && addr == pmicrb_pkg::OFS_CONV0_CTRL_A |=> rdata[7:5] == 3'h0)
    else $error("reserved control bits not zero");

  // Read answer one cycle later
  a_rvalid_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_en |=> rvalid)
    else $error("read answer missing");

  // Read data holds between reads
  a_rdata_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    !rd_en |=> $stable(rdata))
    else $error("read data changed without read");

  // Soft reset pulse on write
  a_srst_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_rst && wdata[0] |=> soft_reset_pulse)
    else $error("soft reset pulse missing");

  // Soft reset only when asked
  a_srst_cause: assert property (@(posedge clk_sys) disable iff (!rstn)
    soft_reset_pulse |-> $past(wr_rst && wdata[0]))
    else $error("soft reset pulse without write");

  // Event sets flag, set wins
  a_flag_set_wins: assert property (@(posedge clk_sys) disable iff (!rstn)
    1'b1 |=> (int_c_q & $past(events.conv)) == ($past(events.conv) & pmicrb_pkg::WM_SUB_INT))
    else $error("event did not set flag");

  // Write of one never sets a flag that is clear and has no event
  a_flag_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_ic |=> (int_c_q & $past(wdata & ~events.conv & ~int_c_q)) == 8'h00)
    else $error("flag set without event");

  // Write one clears flag when no event arrives
  a_flag_cleared: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_ic && events.conv == 8'h00 |=> (int_c_q & $past(wdata)) == 8'h00)
    else $error("flag not cleared by write");

  // Reserved flag bits stay zero
  a_flag_reserved: assert property (@(posedge clk_sys) disable iff (!rstn)
    (int_l_q & ~pmicrb_pkg::WM_SUB_INT) == 8'h00)
    else $error("reserved flag bit set");

  // Pin level taken when stages agree
  a_pin_filter: assert property (@(posedge clk_sys) disable iff (!rstn)
    pin_sync_q[2] == pin_sync_q[1] |=> pin_level_q == $past(pin_sync_q[2]))
    else $error("pin level not taken");

  // Pin level holds while stages differ
  a_pin_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    pin_sync_q[2] != pin_sync_q[1] |=> $stable(pin_level_q))
    else $error("pin level changed on glitch");

  // Load meter select follows write
  a_load_sel: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_sel |=> load_select == $past(wdata[0]))
    else $error("load select not following write");

  c_gated_run: cover property (@(posedge clk_sys) disable iff (!rstn)
    ctrl_q.pin_gating && conv0_drive.run);
  c_discharge: cover property (@(posedge clk_sys) disable iff (!rstn)
    conv0_drive.discharge);
  c_flag_set: cover property (@(posedge clk_sys) disable iff (!rstn) |int_c_q);
  c_flag_clear: cover property (@(posedge clk_sys) disable iff (!rstn)
    wr_ic && |int_c_q);
  c_soft_reset: cover property (@(posedge clk_sys) disable iff (!rstn)
    soft_reset_pulse);
endmodule // pmicrb_regbank
